// File: deu_apb_master.sv
// Purpose: Software side of the unit: an APB master.
// Assumes: Signals change only after a rising edge.
// Notes: Waits at most 16 cycles for pready.
`timescale 1ns/10ps
module deu_apb_master (
	// Clock
	input wire logic mclk,
	// Answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e, output logic ok);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		ok = 1'b0;
		for (int i = 0; i < 16 && !ok; i++) begin
			@(posedge mclk);
			ok = (pready === 1'b1);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : deu_apb_master

// File: deu_char_decode.sv
// Purpose: Decodes one pattern byte against one source digit and picks the result byte.
// Assumes: Pure combinational; the caller registers every output.
// Notes: Bit 7 of a byte is its most significant bit.
`timescale 1ns/10ps
`include "deu_defs.svh"
module deu_char_decode (
	// Operands
	input wire logic [7:0] pat_byte,
	input wire logic [7:0] src_byte,
	input wire logic [7:0] fill,
	// Mode and state
	input wire logic low_sel,
	input wire logic trig,
	input wire logic zone_ascii,
	input wire logic mark_op,
	// Decode results
	output logic examine,
	output logic field_sep,
	output logic digit_nz,
	output logic digit_bad,
	output logic sign_skip,
	output logic trig_next,
	output logic mark_cond,
	output logic [7:0] result
);
	logic sig_start;
	logic [3:0] digit;
	logic [3:0] zone;
	logic sign_plus;

	always_comb begin
		sig_start = (pat_byte == `DEU_CHR_SIG_START);
		examine = (pat_byte == `DEU_CHR_DIGIT_SELECT) || sig_start;
		field_sep = (pat_byte == `DEU_CHR_FIELD_SEP);
		digit = low_sel ? src_byte[3:0] : src_byte[7:4];
		digit_nz = examine && (digit != 4'h0);
		digit_bad = examine && (digit > 4'h9);
		// The sign only sits in the low nibble, so it is judged while the high digit is examined.
		sign_skip = examine && !low_sel && (src_byte[3:0] > 4'h9);
		sign_plus = (src_byte[3:0] == 4'hA) || (src_byte[3:0] == 4'hC) ||
			(src_byte[3:0] == 4'hE) || (src_byte[3:0] == 4'hF);
		zone = zone_ascii ? `DEU_ZONE_ASCII : `DEU_ZONE_EBCDIC;
		trig_next = trig;
		if (field_sep) begin
			trig_next = 1'b0;
		end else if (examine) begin
			trig_next = trig || digit_nz || sig_start;
			if (sign_skip && sign_plus) begin
				trig_next = 1'b0;
			end
		end
		// Fill selection uses the trigger as it stood before this byte.
		if (examine) begin
			result = (!trig && !digit_nz) ? fill : {zone, digit};
		end else if (field_sep) begin
			result = fill;
		end else begin
			result = trig ? pat_byte : fill;
		end
		mark_cond = mark_op && examine && !trig && digit_nz;
	end
endmodule : deu_char_decode

// File: deu_defs.svh
// Purpose: Offsets, field positions, codes and the counter limit of the decimal edit unit.
// Assumes: Included by its bare name from the design files, the checker and the testbench.
// Notes: Definitions only.
`ifndef DEU_DEFS_SVH
`define DEU_DEFS_SVH

// Register byte offsets on the APB.
`define DEU_OFF_CTRL 8'h00
`define DEU_OFF_STATUS 8'h04
`define DEU_OFF_PAT_HI 8'h08
`define DEU_OFF_PAT_LO 8'h0C
`define DEU_OFF_SRC_HI 8'h10
`define DEU_OFF_SRC_LO 8'h14
`define DEU_OFF_COUNT 8'h18
`define DEU_OFF_BADDR 8'h1C
`define DEU_OFF_MARK 8'h20

// Control register bits.
`define DEU_CTRL_START 0
`define DEU_CTRL_RESUME 1
`define DEU_CTRL_MARK_OP 2
`define DEU_CTRL_ZONE_ASCII 3

// Count register fields.
`define DEU_CNT_PAT_LSB 0
`define DEU_CNT_SRC_LSB 4
`define DEU_CNT_LEN_LSB 8
`define DEU_CNT_LOWSEL 16

// Pattern control characters.
`define DEU_CHR_DIGIT_SELECT 8'h20
`define DEU_CHR_SIG_START 8'h21
`define DEU_CHR_FIELD_SEP 8'h22

// Zone nibbles for the two code sets.
`define DEU_ZONE_EBCDIC 4'hF
`define DEU_ZONE_ASCII 4'h5

// Counter limit that forces an exit.
`define DEU_CTR_LAST 3'h7

`endif

// File: deu_edit_unit.sv
// Purpose: Decimal edit and edit-and-mark datapath with its two-cycle sequencer, behind an APB slave.
// Assumes: Software plays the microprogram: it loads words and counters, starts, and refills on exits.
// Notes: One wait state on every APB access; registers are 32-bit aligned words.
// Behaviour
// - Byte 20h is the digit select character.
// - Byte 21h is the significance start character.
// - Byte 22h separates fields, clears trigger.
// - Trigger cleared at every execution start; resume keeps it.
// - Nonzero source digit sets the trigger.
// - Significance start sets trigger for later digits.
// - Zero digit with trigger clear gives fill.
// - First pattern byte captured as fill character.
// - Plus sign clears trigger, minus keeps it.
// - Other bytes kept if significant, else filled.
// - Program status bit 12 picks zone code; here control bit 3.
// - Mark writes bits 0-23, keeps bits 24-31.
// - Mark only on nonzero digit, trigger clear.
// - Pattern bytes left to right, three result sources.
// - Digit examined only for select or start bytes.
// - Fill copied at start, then two-cycle loop.
// - Decode cycle sets or clears nonzero flag, stores nothing.
// - Invalid examined digit sets invalid-data flag.
// - Decode cycles step byte address except first.
// - Write cycle stores byte and steps counters.
// - Half selector toggles; sign skipped when high.
// - Exit priority: mark, length/pattern, then source.
// - Mark condition latched as branch condition.
`timescale 1ns/10ps
`include "deu_defs.svh"
module deu_edit_unit #(
	parameter int ADDR_W = 24,
	parameter int LEN_W = 8
) (
	// Clock, reset and clock enable
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sequencer status
	output logic busy,
	output deu_pkg::deu_exit_t exit_code
);
	import deu_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State.

	deu_state_t state_q, state_d;
	deu_exit_t exit_q, exit_d;
	logic [63:0] pattern_word_reg_q, pattern_word_reg_d;
	logic [63:0] source_word_reg_q, source_word_reg_d;
	logic [2:0] pattern_byte_counter_q, pattern_byte_counter_d;
	logic [2:0] source_byte_counter_q, source_byte_counter_d;
	logic [LEN_W-1:0] length_count_q, length_count_d;
	logic [ADDR_W-1:0] byte_addr_q, byte_addr_d;
	logic [31:0] mark_target_register_q, mark_target_register_d;
	logic [7:0] fill_q, fill_d;
	logic low_sel_q, low_sel_d;
	logic trig_q, trig_d;
	logic first_q, first_d;
	logic mark_op_q, mark_op_d;
	logic zone_ascii_q, zone_ascii_d;
	logic nonzero_q, nonzero_d;
	logic invalid_q, invalid_d;
	logic mark_hit_q, mark_hit_d;
	logic [7:0] result_q, result_d;
	logic advance_q, advance_d;
	logic skip_q, skip_d;
	logic trig_new_q, trig_new_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic busy_q, busy_d;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic [7:0] deu_get_byte(input logic [63:0] word, input logic [2:0] idx);
		deu_get_byte = word[8'(63 - 8 * idx) -: 8];
	endfunction : deu_get_byte

	function automatic logic deu_mapped(input logic [7:0] addr);
		deu_mapped = (addr == `DEU_OFF_CTRL) || (addr == `DEU_OFF_STATUS) ||
			(addr == `DEU_OFF_PAT_HI) || (addr == `DEU_OFF_PAT_LO) ||
			(addr == `DEU_OFF_SRC_HI) || (addr == `DEU_OFF_SRC_LO) ||
			(addr == `DEU_OFF_COUNT) || (addr == `DEU_OFF_BADDR) ||
			(addr == `DEU_OFF_MARK);
	endfunction : deu_mapped

	logic [7:0] cur_pat;
	logic [7:0] cur_src;
	logic dec_examine;
	logic dec_field_sep;
	logic dec_digit_nz;
	logic dec_digit_bad;
	logic dec_sign_skip;
	logic dec_trig_next;
	logic dec_mark_cond;
	logic [7:0] dec_result;

	assign cur_pat = deu_get_byte(pattern_word_reg_q, pattern_byte_counter_q);
	assign cur_src = deu_get_byte(source_word_reg_q, source_byte_counter_q);

	deu_char_decode u_decode (
		.pat_byte(cur_pat),
		.src_byte(cur_src),
		.fill(fill_q),
		.low_sel(low_sel_q),
		.trig(trig_q),
		.zone_ascii(zone_ascii_q),
		.mark_op(mark_op_q),
		.examine(dec_examine),
		.field_sep(dec_field_sep),
		.digit_nz(dec_digit_nz),
		.digit_bad(dec_digit_bad),
		.sign_skip(dec_sign_skip),
		.trig_next(dec_trig_next),
		.mark_cond(dec_mark_cond),
		.result(dec_result)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the sequencer and the register file.

	logic wr_en;
	logic rd_en;
	logic idle;
	logic [31:0] status_word;
	logic [31:0] count_word;
	logic [63:0] pat_written;

	always_comb begin
		state_d = state_q;
		exit_d = exit_q;
		pattern_word_reg_d = pattern_word_reg_q;
		source_word_reg_d = source_word_reg_q;
		pattern_byte_counter_d = pattern_byte_counter_q;
		source_byte_counter_d = source_byte_counter_q;
		length_count_d = length_count_q;
		byte_addr_d = byte_addr_q;
		mark_target_register_d = mark_target_register_q;
		fill_d = fill_q;
		low_sel_d = low_sel_q;
		trig_d = trig_q;
		first_d = first_q;
		mark_op_d = mark_op_q;
		zone_ascii_d = zone_ascii_q;
		nonzero_d = nonzero_q;
		invalid_d = invalid_q;
		mark_hit_d = mark_hit_q;
		result_d = result_q;
		advance_d = advance_q;
		skip_d = skip_q;
		trig_new_d = trig_new_q;
		pat_written = pattern_word_reg_q;
		idle = (state_q == DEU_ST_IDLE);

		// A write is taken at the edge where the slave already shows ready; a read one cycle earlier.
		wr_en = psel && penable && pready_q && pwrite;
		rd_en = psel && penable && !pready_q && !pwrite;
		pready_d = psel && penable && !pready_q;
		pslverr_d = pready_d && !deu_mapped(paddr);
		status_word = {26'h000_0000, exit_q, mark_hit_q, invalid_q, nonzero_q, trig_q};
		count_word = {15'h0000, low_sel_q, length_count_q, 1'b0, source_byte_counter_q,
			1'b0, pattern_byte_counter_q};
		prdata_d = 32'h0000_0000;
		if (rd_en) begin
			unique case (paddr)
				`DEU_OFF_CTRL: prdata_d = {28'h000_0000, zone_ascii_q, mark_op_q, !idle, 1'b0};
				`DEU_OFF_STATUS: prdata_d = status_word;
				`DEU_OFF_PAT_HI: prdata_d = pattern_word_reg_q[63:32];
				`DEU_OFF_PAT_LO: prdata_d = pattern_word_reg_q[31:0];
				`DEU_OFF_SRC_HI: prdata_d = source_word_reg_q[63:32];
				`DEU_OFF_SRC_LO: prdata_d = source_word_reg_q[31:0];
				`DEU_OFF_COUNT: prdata_d = count_word;
				`DEU_OFF_BADDR: prdata_d = {{(32-ADDR_W){1'b0}}, byte_addr_q};
				`DEU_OFF_MARK: prdata_d = mark_target_register_q;
				default: prdata_d = 32'h0000_0000;
			endcase
		end

		// While the loop runs it owns every operand register; writes then are dropped.
		if (wr_en && idle) begin
			unique case (paddr)
				`DEU_OFF_CTRL: begin
					mark_op_d = pwdata[`DEU_CTRL_MARK_OP];
					zone_ascii_d = pwdata[`DEU_CTRL_ZONE_ASCII];
					if (pwdata[`DEU_CTRL_START]) begin
						fill_d = cur_pat;
						trig_d = 1'b0;
						nonzero_d = 1'b0;
						invalid_d = 1'b0;
						mark_hit_d = 1'b0;
						first_d = 1'b1;
						exit_d = DEU_EXIT_NONE;
						state_d = DEU_ST_DECODE;
					end else if (pwdata[`DEU_CTRL_RESUME]) begin
						first_d = 1'b1;
						mark_hit_d = 1'b0;
						exit_d = DEU_EXIT_NONE;
						state_d = DEU_ST_DECODE;
					end
				end
				`DEU_OFF_PAT_HI: pattern_word_reg_d[63:32] = pwdata;
				`DEU_OFF_PAT_LO: pattern_word_reg_d[31:0] = pwdata;
				`DEU_OFF_SRC_HI: source_word_reg_d[63:32] = pwdata;
				`DEU_OFF_SRC_LO: source_word_reg_d[31:0] = pwdata;
				`DEU_OFF_COUNT: begin
					pattern_byte_counter_d = pwdata[`DEU_CNT_PAT_LSB +: 3];
					source_byte_counter_d = pwdata[`DEU_CNT_SRC_LSB +: 3];
					length_count_d = pwdata[`DEU_CNT_LEN_LSB +: LEN_W];
					low_sel_d = pwdata[`DEU_CNT_LOWSEL];
				end
				`DEU_OFF_BADDR: byte_addr_d = pwdata[ADDR_W-1:0];
				`DEU_OFF_MARK: mark_target_register_d = pwdata;
				default: begin
				end
			endcase
		end

		unique case (state_q)
			DEU_ST_IDLE: begin
			end
			DEU_ST_DECODE: begin
				// Only decode here; results wait in flops for the write cycle.
				result_d = dec_result;
				advance_d = dec_examine;
				skip_d = dec_sign_skip;
				trig_new_d = dec_trig_next;
				if (dec_digit_nz) begin
					nonzero_d = 1'b1;
				end else if (dec_field_sep) begin
					nonzero_d = 1'b0;
				end
				if (dec_digit_bad) begin
					invalid_d = 1'b1;
				end
				if (!first_q) begin
					byte_addr_d = byte_addr_q + ADDR_W'(1);
				end
				first_d = 1'b0;
				mark_hit_d = dec_mark_cond;
				state_d = DEU_ST_WRITE;
			end
			DEU_ST_WRITE: begin
				pat_written[8'(63 - 8 * pattern_byte_counter_q) -: 8] = result_q;
				pattern_word_reg_d = pat_written;
				pattern_byte_counter_d = pattern_byte_counter_q + 3'h1;
				length_count_d = length_count_q - LEN_W'(1);
				trig_d = trig_new_q;
				if (mark_hit_q) begin
					mark_target_register_d = {mark_target_register_q[31:ADDR_W], byte_addr_q};
				end
				if (advance_q) begin
					// A sign in the low half is skipped by stepping the byte and staying high.
					if (skip_q || low_sel_q) begin
						source_byte_counter_d = source_byte_counter_q + 3'h1;
						low_sel_d = 1'b0;
					end else begin
						low_sel_d = 1'b1;
					end
				end
				// Counters are judged as they stood when this byte was handled.
				if (mark_hit_q) begin
					exit_d = DEU_EXIT_MARK;
					state_d = DEU_ST_IDLE;
				end else if ((length_count_q == '0) || (pattern_byte_counter_q == `DEU_CTR_LAST)) begin
					exit_d = DEU_EXIT_PATTERN;
					state_d = DEU_ST_IDLE;
				end else if (source_byte_counter_q == `DEU_CTR_LAST) begin
					exit_d = DEU_EXIT_SOURCE;
					state_d = DEU_ST_IDLE;
				end else begin
					state_d = DEU_ST_DECODE;
				end
			end
		endcase
		// Registered so that the busy output comes straight from a flop.
		busy_d = (state_d != DEU_ST_IDLE);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= DEU_ST_IDLE;
			exit_q <= DEU_EXIT_NONE;
			pattern_word_reg_q <= 64'h0000_0000_0000_0000;
			source_word_reg_q <= 64'h0000_0000_0000_0000;
			pattern_byte_counter_q <= 3'h0;
			source_byte_counter_q <= 3'h0;
			length_count_q <= '0;
			byte_addr_q <= '0;
			mark_target_register_q <= 32'h0000_0000;
			fill_q <= 8'h00;
			low_sel_q <= 1'b0;
			trig_q <= 1'b0;
			first_q <= 1'b0;
			mark_op_q <= 1'b0;
			zone_ascii_q <= 1'b0;
			nonzero_q <= 1'b0;
			invalid_q <= 1'b0;
			mark_hit_q <= 1'b0;
			result_q <= 8'h00;
			advance_q <= 1'b0;
			skip_q <= 1'b0;
			trig_new_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			exit_q <= exit_d;
			pattern_word_reg_q <= pattern_word_reg_d;
			source_word_reg_q <= source_word_reg_d;
			pattern_byte_counter_q <= pattern_byte_counter_d;
			source_byte_counter_q <= source_byte_counter_d;
			length_count_q <= length_count_d;
			byte_addr_q <= byte_addr_d;
			mark_target_register_q <= mark_target_register_d;
			fill_q <= fill_d;
			low_sel_q <= low_sel_d;
			trig_q <= trig_d;
			first_q <= first_d;
			mark_op_q <= mark_op_d;
			zone_ascii_q <= zone_ascii_d;
			nonzero_q <= nonzero_d;
			invalid_q <= invalid_d;
			mark_hit_q <= mark_hit_d;
			result_q <= result_d;
			advance_q <= advance_d;
			skip_q <= skip_d;
			trig_new_q <= trig_new_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			busy_q <= busy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flops.

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign busy = busy_q;
	assign exit_code = exit_q;
endmodule : deu_edit_unit

// File: deu_edit_unit_assertions.sv
// Purpose: Port-level checks of the decimal edit unit.
// Assumes: Bound to deu_edit_unit; ce held high.
// Notes: Loop length is tracked by a parity flop.
`timescale 1ns/10ps
`include "deu_defs.svh"
module deu_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sequencer
	input wire logic busy,
	input wire deu_pkg::deu_exit_t exit_code
);
	import deu_pkg::*;
	logic par_q;
	logic par_d;
	// Every byte costs two cycles, so a run must end on even parity.
	always_comb begin
		par_d = busy ? ~par_q : 1'b0;
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			par_q <= 1'b0;
		end else begin
			par_q <= par_d;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	//////////////////////////////////////////
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero outside answer");
	chk_start_cause: assert property (
		$rose(busy) |-> $past(psel) && $past(penable) && $past(pready) && $past(pwrite) &&
		($past(paddr) == `DEU_OFF_CTRL))
		else $error("loop started without control write");
	chk_loop_two: assert property ($rose(busy) |-> busy ##1 busy)
		else $error("loop shorter than two cycles");
	chk_loop_even: assert property ($fell(busy) |-> !par_q)
		else $error("loop ended in mid byte");
	chk_exit_set: assert property ($fell(busy) |-> exit_code != DEU_EXIT_NONE)
		else $error("loop ended without exit code");
	chk_exit_clear: assert property (busy |-> exit_code == DEU_EXIT_NONE)
		else $error("exit code set while running");
	chk_exit_hold: assert property (!$past(busy) && !busy |-> $stable(exit_code))
		else $error("exit code changed while idle");
	cover property (exit_code == DEU_EXIT_MARK);
	cover property ($fell(busy) && exit_code == DEU_EXIT_SOURCE);
	cover property (pslverr);
endmodule : deu_chk
bind deu_edit_unit deu_chk u_chk (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.busy(busy), .exit_code(exit_code));

// File: deu_pkg.sv
// Purpose: Types shared by the decimal edit unit.
// Assumes: deu_defs.svh holds the numeric constants.
// Notes: None.
package deu_pkg;
	typedef enum logic [1:0] {DEU_ST_IDLE, DEU_ST_DECODE, DEU_ST_WRITE} deu_state_t;
	typedef enum logic [1:0] {DEU_EXIT_NONE, DEU_EXIT_MARK, DEU_EXIT_PATTERN, DEU_EXIT_SOURCE} deu_exit_t;
endpackage : deu_pkg

// File: test_deu_edit_unit.sv
// Purpose: Self-checking bench for the decimal edit unit.
// Assumes: The APB master model plays the microprogram; ce tied high.
// Notes: Byte 0 of a word sits in bits 31:24.
`timescale 1ns/10ps
`include "deu_defs.svh"
module test_deu_edit_unit;
	import deu_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	deu_exit_t exit_code;
	int n_errors = 0;
	int n_compared = 0;
	always #2 mclk = ~mclk;
	deu_edit_unit u_dut (.mclk(mclk), .reset(reset), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy), .exit_code(exit_code));
	deu_apb_master u_mst (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	//////////////////////////////////////////
	task summarize;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		logic ok;
		u_mst.xfer(w, a, d, r, e, ok);
		if (ok !== 1'b1) begin
			n_errors++;
			$display("ERROR pready expected 1 seen 0");
			summarize();
		end
	endtask : xf
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xf(1'b1, a, d, r, e);
	endtask : wr
	task rdc(input string what, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFF_FFFF);
		logic [31:0] r;
		logic e;
		xf(1'b0, a, 32'h0000_0000, r, e);
		check(what, r & m, exp);
	endtask : rdc
	task go(input logic [31:0] ph, pl, sh, cnt, ctl);
		wr(`DEU_OFF_PAT_HI, ph);
		wr(`DEU_OFF_PAT_LO, pl);
		wr(`DEU_OFF_SRC_HI, sh);
		wr(`DEU_OFF_SRC_LO, 32'h0000_0000);
		wr(`DEU_OFF_COUNT, cnt);
		wr(`DEU_OFF_CTRL, ctl);
	endtask : go
	// Bounded wait; a hung loop ends the run here.
	task idle;
		for (int i = 0; i < 300; i++) begin
			@(posedge mclk);
			if (busy === 1'b0) return;
		end
		n_errors++;
		$display("ERROR busy expected 0 seen 1");
		summarize();
	endtask : idle
	task ex(input deu_exit_t x);
		check("exit_code", {30'h0, exit_code}, {30'h0, x});
	endtask : ex
	//////////////////////////////////////////
	task t_reset;
		logic [31:0] r;
		logic e;
		rdc("status", `DEU_OFF_STATUS, 32'h0000_0000);
		rdc("count", `DEU_OFF_COUNT, 32'h0000_0000);
		xf(1'b0, 8'h40, 32'h0000_0000, r, e);
		check("unmapped_err", {31'h0, e}, 32'h0000_0001);
		check("unmapped_data", r, 32'h0000_0000);
		wr(`DEU_OFF_STATUS, 32'hFFFF_FFFF);
		rdc("status_ro", `DEU_OFF_STATUS, 32'h0000_0000);
	endtask : t_reset
	// Sig start on a zero, comma, plus sign, separator; a write while busy is dropped.
	task t_edit;
		go(32'h4021_206B, 32'h20C3_D922, 32'h012C_0000, 32'h0000_0700, 32'h0000_0001);
		wr(`DEU_OFF_PAT_HI, 32'h0000_0000);
		rdc("busy", `DEU_OFF_CTRL, 32'h0000_0002, 32'h0000_0002);
		idle();
		ex(DEU_EXIT_PATTERN);
		rdc("pat_hi", `DEU_OFF_PAT_HI, 32'h4040_F16B);
		rdc("pat_lo", `DEU_OFF_PAT_LO, 32'hF240_4040);
		rdc("count", `DEU_OFF_COUNT, 32'h0000_FF20);
		rdc("status", `DEU_OFF_STATUS, 32'h0000_0020);
	endtask : t_edit
	// Asterisk fill, second zone set, minus sign keeps CR.
	task t_minus;
		go(32'h5C20_2020, 32'hC3D9_2120, 32'h050D_3900, 32'h0000_0700, 32'h0000_0009);
		idle();
		rdc("pat_hi", `DEU_OFF_PAT_HI, 32'h5C5C_5550);
		rdc("pat_lo", `DEU_OFF_PAT_LO, 32'hC3D9_5359);
		rdc("count", `DEU_OFF_COUNT, 32'h0000_FF30);
		rdc("status", `DEU_OFF_STATUS, 32'h0000_0023);
	endtask : t_minus
	task t_prio;
		logic [31:0] cnt [3];
		logic [31:0] aft [3];
		deu_exit_t x [3];
		cnt = '{32'h0000_0770, 32'h0000_0777, 32'h0000_0000};
		aft = '{32'h0000_0671, 32'h0000_0670, 32'h0000_FF01};
		x = '{DEU_EXIT_SOURCE, DEU_EXIT_PATTERN, DEU_EXIT_PATTERN};
		for (int i = 0; i < 3; i++) begin
			go(32'h4040_4040, 32'h4040_4040, 32'h0000_0000, cnt[i], 32'h0000_0001);
			idle();
			ex(x[i]);
			rdc("count", `DEU_OFF_COUNT, aft[i]);
			rdc("trigger", `DEU_OFF_STATUS, 32'h0000_0000, 32'h0000_0001);
		end
	endtask : t_prio
	task t_invalid;
		go(32'h4020_4040, 32'h4040_4040, 32'hA100_0000, 32'h0000_0700, 32'h0000_0001);
		idle();
		rdc("invalid", `DEU_OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
	endtask : t_invalid
	// Mark on the first significant digit, then resume past a separator and a forced start.
	task t_mark;
		wr(`DEU_OFF_MARK, 32'hAB00_0000);
		wr(`DEU_OFF_BADDR, 32'h0000_0100);
		go(32'h4020_2022, 32'h2120_2040, 32'h0103_4C00, 32'h0000_0700, 32'h0000_0005);
		idle();
		ex(DEU_EXIT_MARK);
		rdc("mark", `DEU_OFF_MARK, 32'hAB00_0102);
		rdc("count", `DEU_OFF_COUNT, 32'h0000_0413);
		rdc("latched", `DEU_OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
		wr(`DEU_OFF_CTRL, 32'h0000_0006);
		idle();
		ex(DEU_EXIT_PATTERN);
		rdc("mark", `DEU_OFF_MARK, 32'hAB00_0102);
		rdc("pat_hi", `DEU_OFF_PAT_HI, 32'h4040_F140);
		rdc("pat_lo", `DEU_OFF_PAT_LO, 32'h40F3_F440);
		rdc("byte_addr", `DEU_OFF_BADDR, 32'h0000_0106);
	endtask : t_mark
	//////////////////////////////////////////
	initial begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		t_reset();
		t_edit();
		t_minus();
		t_prio();
		t_invalid();
		t_mark();
		summarize();
	end
endmodule : test_deu_edit_unit
